// File: rtl/rssirq_defs.vh
//==================================================================
// Contract
// - receive mode is active when chip operating mode equals binary 011.
// - IF gain selects -13.5 to 0 dB in 4.5 dB steps, reset 0 dB.
// - one polyphase enable bit switches low-pass versus complex polyphase filtering.
// - reported signal strength has a 0.5 dB least significant step.
// - in on-off keying, sample I and Q sixteen times per IF2 period; the code takes the sample period from the deviation register in both modes.
// - in frequency-shift keying, sample sixteen times per deviation period.
// - strength result is the mean of the latest sixteen samples.
// - readable strength refreshes sixteen times per deviation or IF2 period.
// - strength above threshold raises the strength interrupt status.
// - status clears only by writing one; writing zero leaves it.
// - two routing bits steer the strength interrupt to pin a or b.
//==================================================================
`ifndef RSSIRQ_DEFS_VH
`define RSSIRQ_DEFS_VH

// register offsets
`define RSSIRQ_A_MODE      4'h0
`define RSSIRQ_A_RXCFG     4'h1
`define RSSIRQ_A_DEV       4'h2
`define RSSIRQ_A_THRESH    4'h3
`define RSSIRQ_A_ROUTE     4'h4
`define RSSIRQ_A_STRENGTH  4'h5
`define RSSIRQ_A_STATUS    4'h6
`define RSSIRQ_A_CLEAR     4'h7
`define RSSIRQ_A_ENABLE    4'h8

// field positions
`define RSSIRQ_MODE_W       3
`define RSSIRQ_MODE_RX      3'h3
`define RSSIRQ_GAIN_LSB     0
`define RSSIRQ_POLY_BIT     2
`define RSSIRQ_OOK_BIT      3
`define RSSIRQ_CENTER_LSB   4
`define RSSIRQ_ROUTE_A_BIT  0
`define RSSIRQ_ROUTE_B_BIT  1
`define RSSIRQ_ST_STRENGTH  0
`define RSSIRQ_ST_RXENTRY   1

// reset values
`define RSSIRQ_MODE_RST     3'h0
`define RSSIRQ_RXCFG_RST    8'h00
`define RSSIRQ_DEV_RST      8'h03
`define RSSIRQ_THRESH_RST   8'hFF

// sample timing: deviation/16 = fxtal/(32*(1+dev)), in CLOCK cycles
`define RSSIRQ_SMP_BASE     16'h0020
`define RSSIRQ_NSAMPLES     16
`define RSSIRQ_AVG_SHIFT    4

`endif

// File: rtl/rssirq_win_mem.v
`timescale 1ns/100ps
//==================================================================
// sixteen-entry sample store, registered read
module rssirq_win_mem (
    input  wire       CLOCK,
    input  wire       NRST,
    input  wire       wr_en,
    input  wire [3:0] wr_addr,
    input  wire [7:0] wr_data,
    input  wire [3:0] rd_addr,
    output reg  [7:0] rd_data_ff
);
    reg [7:0] mem [0:15];

    always @(posedge CLOCK) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            rd_data_ff <= 8'h00;
        end else begin
            rd_data_ff <= mem[rd_addr];
        end
    end
endmodule // rssirq_win_mem

// File: rtl/rssirq_sync.v
`timescale 1ns/100ps
//==================================================================
// two-stage synchroniser for pin buses
module rssirq_sync #(
    parameter W = 8
) (
    input  wire         CLOCK,
    input  wire         NRST,
    input  wire [W-1:0] d,
    output reg  [W-1:0] q_ff
);
    reg [W-1:0] meta_ff;

    always @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            meta_ff <= {W{1'b0}};
            q_ff    <= {W{1'b0}};
        end else begin
            meta_ff <= d;
            q_ff    <= meta_ff;
        end
    end
endmodule // rssirq_sync

// File: rtl/rssirq_top.v
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`include "rssirq_defs.vh"
//==================================================================
module rssirq_top (
    input  wire       CLOCK,
    input  wire       NRST,
    input  wire [3:0] ADDR,
    input  wire [7:0] WDATA,
    input  wire       WR,
    input  wire       RD,
    output reg  [7:0] RDATA,
    input  wire [7:0] I_LEVEL,
    input  wire [7:0] Q_LEVEL,
    output reg        RX_MODE,
    output reg  [1:0] IF_GAIN,
    output reg        POLY_EN,
    output reg  [2:0] POLY_CENTER,
    output reg        SAMPLE_STROBE,
    output reg        PIN_A,
    output reg        PIN_B,
    output reg        IRQ
);
    //==============================================================
    // registers
    reg  [2:0]  mode_ff;
    reg  [7:0]  rxcfg_ff;
    reg  [7:0]  dev_ff;
    reg  [7:0]  thresh_ff;
    reg  [1:0]  route_ff;
    reg  [1:0]  status_ff;
    reg  [1:0]  enable_ff;
    reg  [7:0]  strength_ff;
    reg  [15:0] div_cnt_ff;
    reg         smp_ff;
    reg  [3:0]  wptr_ff;
    reg  [11:0] sum_ff;
    reg         upd_ff;
    reg         prev_rx_ff;
    reg         fill_ff;
    wire [7:0]  i_s;
    wire [7:0]  q_s;
    wire [7:0]  old_smp;
    reg  [7:0]  mag;
    reg  [11:0] nxt_sum;
    reg  [1:0]  nxt_status;
    reg  [15:0] period;

    wire wr_mode   = WR && (ADDR == `RSSIRQ_A_MODE);
    wire wr_clear  = WR && (ADDR == `RSSIRQ_A_CLEAR);
    wire rx_active = (mode_ff == `RSSIRQ_MODE_RX);

    // |x-128|: I/Q arrive offset-binary around mid-scale
    function [7:0] absdev;
        input [7:0] v;
        begin
            absdev = v[7] ? {1'b0, v[6:0]} : (8'h80 - v);
        end
    endfunction

    rssirq_sync #(.W(8)) u_sync_i (
        .CLOCK (CLOCK),
        .NRST  (NRST),
        .d     (I_LEVEL),
        .q_ff  (i_s)
    );

    rssirq_sync #(.W(8)) u_sync_q (
        .CLOCK (CLOCK),
        .NRST  (NRST),
        .d     (Q_LEVEL),
        .q_ff  (q_s)
    );

    //==============================================================
    // register writes
    always @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            mode_ff   <= `RSSIRQ_MODE_RST;
            rxcfg_ff  <= `RSSIRQ_RXCFG_RST;
            dev_ff    <= `RSSIRQ_DEV_RST;
            thresh_ff <= `RSSIRQ_THRESH_RST;
            route_ff  <= 2'h0;
            enable_ff <= 2'h0;
        end else if (WR) begin
            case (ADDR)
                `RSSIRQ_A_MODE:   mode_ff   <= WDATA[2:0];
                `RSSIRQ_A_RXCFG:  rxcfg_ff  <= WDATA;
                `RSSIRQ_A_DEV:    dev_ff    <= WDATA;
                `RSSIRQ_A_THRESH: thresh_ff <= WDATA;
                `RSSIRQ_A_ROUTE:  route_ff  <= WDATA[1:0];
                `RSSIRQ_A_ENABLE: enable_ff <= WDATA[1:0];
                default:          mode_ff   <= mode_ff;
            endcase
        end
    end

    //==============================================================
    // sample timer: 16 samples per deviation (fsk) or IF2 (ook) period
    // ook relies on the host loading the deviation with IF2's code
    always @* begin
        period = `RSSIRQ_SMP_BASE * ({8'h00, dev_ff} + 16'h0001) - 16'h0001;
    end

    always @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            div_cnt_ff <= 16'h0000;
            smp_ff     <= 1'b0;
        end else if (!rx_active) begin
            div_cnt_ff <= 16'h0000;
            smp_ff     <= 1'b0;
        end else if (div_cnt_ff >= period) begin
            div_cnt_ff <= 16'h0000;
            smp_ff     <= 1'b1;
        end else begin
            div_cnt_ff <= div_cnt_ff + 16'h0001;
            smp_ff     <= 1'b0;
        end
    end

    //==============================================================
    // sliding 16-sample mean; old sample read one cycle ahead
    always @* begin
        mag = (absdev(i_s) > absdev(q_s)) ? absdev(i_s) : absdev(q_s);
        nxt_sum = sum_ff + {4'h0, mag} - (fill_ff ? {4'h0, old_smp} : 12'h000);
    end

    rssirq_win_mem u_win (
        .CLOCK      (CLOCK),
        .NRST       (NRST),
        .wr_en      (smp_ff),
        .wr_addr    (wptr_ff),
        .wr_data    (mag),
        .rd_addr    (wptr_ff),
        .rd_data_ff (old_smp)
    );

    always @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            wptr_ff     <= 4'h0;
            sum_ff      <= 12'h000;
            fill_ff     <= 1'b0;
            strength_ff <= 8'h00;
            upd_ff      <= 1'b0;
        end else if (!rx_active) begin
            wptr_ff <= 4'h0;
            sum_ff  <= 12'h000;
            fill_ff <= 1'b0;
            upd_ff  <= 1'b0;
        end else if (smp_ff) begin
            wptr_ff     <= wptr_ff + 4'h1;
            sum_ff      <= nxt_sum;
            if (wptr_ff == 4'hF) begin
                fill_ff <= 1'b1;
            end
            // mean in 0.5 dB counts
            strength_ff <= nxt_sum[11:4];
            upd_ff      <= 1'b1;
        end else begin
            upd_ff <= 1'b0;
        end
    end

    //==============================================================
    // status: set wins over clear; flag sticks regardless of level
    always @* begin
        nxt_status = status_ff;
        if (wr_clear) begin
            nxt_status = status_ff & ~WDATA[1:0];
        end
        if (upd_ff && (strength_ff > thresh_ff)) begin
            nxt_status[`RSSIRQ_ST_STRENGTH] = 1'b1;
        end
        if (rx_active && !prev_rx_ff) begin
            nxt_status[`RSSIRQ_ST_RXENTRY] = 1'b1;
        end
    end

    always @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            status_ff  <= 2'h0;
            prev_rx_ff <= 1'b0;
        end else begin
            status_ff  <= nxt_status;
            prev_rx_ff <= rx_active;
        end
    end

    //==============================================================
    // outputs and read port
    always @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            RDATA         <= 8'h00;
            RX_MODE       <= 1'b0;
            IF_GAIN       <= 2'h0;
            POLY_EN       <= 1'b0;
            POLY_CENTER   <= 3'h0;
            SAMPLE_STROBE <= 1'b0;
            PIN_A         <= 1'b0;
            PIN_B         <= 1'b0;
            IRQ           <= 1'b0;
        end else begin
            RX_MODE       <= rx_active;
            IF_GAIN       <= rxcfg_ff[`RSSIRQ_GAIN_LSB+1:`RSSIRQ_GAIN_LSB];
            POLY_EN       <= rxcfg_ff[`RSSIRQ_POLY_BIT];
            POLY_CENTER   <= rxcfg_ff[`RSSIRQ_CENTER_LSB+2:`RSSIRQ_CENTER_LSB];
            SAMPLE_STROBE <= smp_ff;
            PIN_A <= route_ff[`RSSIRQ_ROUTE_A_BIT] & nxt_status[`RSSIRQ_ST_STRENGTH];
            PIN_B <= route_ff[`RSSIRQ_ROUTE_B_BIT] & nxt_status[`RSSIRQ_ST_STRENGTH];
            IRQ   <= |(nxt_status & enable_ff);
            if (RD) begin
                case (ADDR)
                    `RSSIRQ_A_MODE:     RDATA <= {5'h00, mode_ff};
                    `RSSIRQ_A_RXCFG:    RDATA <= rxcfg_ff;
                    `RSSIRQ_A_DEV:      RDATA <= dev_ff;
                    `RSSIRQ_A_THRESH:   RDATA <= thresh_ff;
                    `RSSIRQ_A_ROUTE:    RDATA <= {6'h00, route_ff};
                    `RSSIRQ_A_STRENGTH: RDATA <= strength_ff;
                    `RSSIRQ_A_STATUS:   RDATA <= {6'h00, status_ff};
                    `RSSIRQ_A_ENABLE:   RDATA <= {6'h00, enable_ff};
                    default:            RDATA <= 8'h00;
                endcase
            end else begin
                RDATA <= 8'h00;
            end
        end
    end

    // unused: bit 3 of rx config reserved, mode write pulse; rx entry is detected from prev_rx_ff
    wire unused_ok = wr_mode & rxcfg_ff[`RSSIRQ_OOK_BIT];
endmodule // rssirq_top

// File: sim/rssirq_iq_src.sv
`timescale 1ns/100ps
//==================================================
// baseband source of constant magnitude
module rssirq_iq_src (
    input  wire       CLOCK,
    input  wire [7:0] amp,
    output reg  [7:0] i_lvl = 8'h80,
    output reg  [7:0] q_lvl = 8'h80
);
    reg ph_ff = 1'b0;
    always @(posedge CLOCK) begin
        ph_ff <= ~ph_ff;
        // sign flips each cycle, so a sampler stuck on one value shows
        i_lvl <= ph_ff ? 8'h80 + amp : 8'h80 - amp;
        q_lvl <= 8'h80 + (amp >> 1);
    end
endmodule // rssirq_iq_src

// File: sim/rssirq_properties.sv
`timescale 1ns/100ps
//==================================================
module rssirq_properties (
    input wire       CLOCK,
    input wire       NRST,
    input wire [3:0] ADDR,
    input wire [7:0] WDATA,
    input wire       WR,
    input wire       SAMPLE_STROBE,
    input wire       RX_MODE,
    input wire [1:0] IF_GAIN,
    input wire       POLY_EN,
    input wire [2:0] POLY_CENTER,
    input wire       PIN_A,
    input wire       PIN_B
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!NRST);
    a_rx_mode_code: assert property (
        WR && ADDR == 4'h0 |-> ##2 RX_MODE == ($past(WDATA[2:0], 2) == 3'h3))
        else $error("rx mode wrong");
    a_gain_follow: assert property (
        WR && ADDR == 4'h1 |-> ##2 IF_GAIN == $past(WDATA[1:0], 2))
        else $error("gain wrong");
    a_poly_follow: assert property (
        WR && ADDR == 4'h1 |-> ##2 POLY_EN == $past(WDATA[2], 2))
        else $error("poly enable wrong");
    a_strobe_spacing: assert property (
        SAMPLE_STROBE |=> !SAMPLE_STROBE [*8])
        else $error("strobes too close");
    a_strobe_in_rx: assert property (
        SAMPLE_STROBE |-> RX_MODE || $past(RX_MODE) || $past(RX_MODE, 2))
        else $error("strobe outside receive");
    a_flag_sticky: assert property (
        PIN_A && !WR && !$past(WR) |=> PIN_A)
        else $error("pin a dropped alone");
    a_pin_drop: assert property (
        $fell(PIN_A) |-> $past(WR) || $past(WR, 2))
        else $error("pin a fell without write");
    a_route_off: assert property (
        WR && ADDR == 4'h4 && WDATA[1:0] == 2'h0 |-> ##2 !PIN_A && !PIN_B)
        else $error("pin driven unrouted");
endmodule // rssirq_properties

bind rssirq_top rssirq_properties chk_u (.CLOCK(CLOCK), .NRST(NRST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .SAMPLE_STROBE(SAMPLE_STROBE), .RX_MODE(RX_MODE),
    .IF_GAIN(IF_GAIN), .POLY_EN(POLY_EN), .POLY_CENTER(POLY_CENTER),
    .PIN_A(PIN_A), .PIN_B(PIN_B));

// File: sim/rssirq_bench.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
    $display("FAIL %s exp %h got %h", nm, e, g); end end
module rssirq_bench;
    localparam CENTER_100K = 3'h0;
    reg        CLOCK = 1'b0;
    reg        NRST = 1'b0;
    reg  [3:0] ADDR = 4'h0;
    reg  [7:0] WDATA = 8'h00;
    reg        WR = 1'b0;
    reg        RD = 1'b0;
    reg  [7:0] amp = 8'h00;
    reg        rd_pend = 1'b0;
    reg  [7:0] exp_v;
    reg  [7:0] cfg;
    wire [7:0] RDATA, i_lvl, q_lvl;
    wire [1:0] IF_GAIN;
    wire [2:0] POLY_CENTER;
    wire       RX_MODE, POLY_EN, SAMPLE_STROBE, PIN_A, PIN_B, IRQ;
    int        mismatches = 0, n_compared = 0, cyc = 0, k;
    logic [7:0] exp_q[$];

    rssirq_top dut_u (.CLOCK(CLOCK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
        .RD(RD), .RDATA(RDATA), .I_LEVEL(i_lvl), .Q_LEVEL(q_lvl), .RX_MODE(RX_MODE),
        .IF_GAIN(IF_GAIN), .POLY_EN(POLY_EN), .POLY_CENTER(POLY_CENTER),
        .SAMPLE_STROBE(SAMPLE_STROBE), .PIN_A(PIN_A), .PIN_B(PIN_B), .IRQ(IRQ));
    rssirq_iq_src src_u (.CLOCK(CLOCK), .amp(amp), .i_lvl(i_lvl), .q_lvl(q_lvl));

    initial forever #25 CLOCK = ~CLOCK;

    task stop_test;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // hang guard, well above the roughly 1100 cycles the run needs
    always @(posedge CLOCK) begin
        rd_pend <= RD;
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            mismatches++;
            stop_test;
        end
    end
    always @(negedge CLOCK) if (rd_pend) begin
        exp_v = exp_q.pop_front();
        `CHK("rdata", exp_v, RDATA)
    end

    task automatic wr(input [3:0] a, input [7:0] d);
        @(posedge CLOCK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLOCK);
        WR <= 1'b0;
        repeat (2) @(negedge CLOCK);
    endtask
    task automatic rd(input [3:0] a, input [7:0] e);
        @(posedge CLOCK);
        ADDR <= a;
        RD <= 1'b1;
        exp_q.push_back(e);
        @(posedge CLOCK);
        RD <= 1'b0;
    endtask
    task automatic strobes(input int n);
        repeat (n) do @(negedge CLOCK); while (SAMPLE_STROBE !== 1'b1);
    endtask
    task automatic period(input int e);
        strobes(1);
        k = 0;
        do begin
            @(negedge CLOCK);
            k++;
        end while (SAMPLE_STROBE !== 1'b1);
        `CHK("period", e, k)
    endtask

    initial begin
        k = $urandom(30903);
        amp = 8'($urandom_range(126, 1));
        repeat (4) @(posedge CLOCK);
        NRST <= 1'b1;
        for (int a = 0; a < 16; a++) rd(a[3:0], a == 2 ? 8'h03 : a == 3 ? 8'hFF : 8'h00);
        `CHK("gain_rst", 2'h0, IF_GAIN)
        for (int m = 0; m < 8; m++) begin
            wr(4'h0, m[7:0]);
            `CHK("rx_mode", m == 3, RX_MODE)
        end
        for (int g = 0; g < 4; g++) begin
            cfg = {1'b0, 3'($urandom), 1'b0, g[0], g[1:0]};
            wr(4'h1, cfg);
            `CHK("gain", cfg[1:0], IF_GAIN)
            `CHK("poly", {cfg[6:4], cfg[2]}, {POLY_CENTER, POLY_EN})
        end
        wr(4'h1, {1'b0, CENTER_100K, 4'h4});
        wr(4'h2, 8'h03);
        wr(4'h0, 8'h03);
        period(128);
        wr(4'h2, 8'h00);
        period(32);
        wr(4'h0, 8'h00);
        wr(4'h0, 8'h03);
        strobes(8);
        rd(4'h5, (amp * 8) >> 4);
        strobes(8);
        rd(4'h5, amp);
        rd(4'h6, 8'h02);
        wr(4'h7, 8'hFF);
        wr(4'h4, 8'h01);
        wr(4'h8, 8'h01);
        wr(4'h3, amp - 8'h01);
        strobes(1);
        repeat (2) @(negedge CLOCK);
        `CHK("pins", 3'b101, {IRQ, PIN_B, PIN_A})
        rd(4'h6, 8'h01);
        wr(4'h7, 8'h00);
        wr(4'h3, 8'hFF);
        strobes(2);
        `CHK("sticky", 1'b1, PIN_A)
        wr(4'h8, 8'h00);
        `CHK("masked", 1'b0, IRQ)
        wr(4'h7, 8'h01);
        `CHK("cleared", 1'b0, PIN_A)
        wr(4'h4, 8'h02);
        wr(4'h3, amp - 8'h01);
        strobes(1);
        repeat (2) @(negedge CLOCK);
        `CHK("pin_b", 2'b10, {PIN_B, PIN_A})
        wr(4'h4, 8'h00);
        `CHK("unrouted", 2'b00, {PIN_B, PIN_A})
        repeat (3) @(posedge CLOCK);
        stop_test;
    end
endmodule // rssirq_bench
